// ---- inc/sdcc_pkg.sv ----
// Package for the card command and data control block.
// Assumes a 32-bit APB slave and a card clock sampled by the system clock.
package sdcc_pkg;

  // Register byte offsets
  localparam logic [7:0] SDCC_OFF_CONFIG = 8'h10;
  localparam logic [7:0] SDCC_OFF_XFER_CTRL = 8'h14;
  localparam logic [7:0] SDCC_OFF_CMD_ARG = 8'h18;
  localparam logic [7:0] SDCC_OFF_CMD_ISSUE = 8'h1c;
  localparam logic [7:0] SDCC_OFF_INT_STATUS = 8'h40;
  localparam logic [7:0] SDCC_OFF_INT_CLEAR = 8'h44;
  localparam logic [7:0] SDCC_OFF_INT_ENABLE = 8'h48;

  // Transfer control fields
  localparam int SDCC_XFER_LEN_LSB = 16;
  localparam int SDCC_XFER_LEN_W = 16;
  localparam int SDCC_XFER_GO_BIT = 1;
  localparam int SDCC_XFER_DIR_BIT = 0;

  // Command issue fields
  localparam int SDCC_CMD_RESP_LSB = 8;
  localparam int SDCC_CMD_RESP_W = 3;
  localparam int SDCC_CMD_DATA_BIT = 6;
  localparam int SDCC_CMD_INDEX_W = 6;

  // Configuration fields
  localparam int SDCC_CFG_WIDTH_LSB = 12;
  localparam int SDCC_CFG_BSIZE_W = 4;

  // Interrupt status layout
  localparam int SDCC_INT_W = 4;
  localparam int SDCC_INT_XFER_DONE = 0;
  localparam int SDCC_INT_BLOCK_DONE = 1;
  localparam int SDCC_INT_CARD_IRQ = 2;
  localparam int SDCC_INT_CMD_SENT = 3;

  // Reset values
  localparam logic [31:0] SDCC_RESET_WORD = 32'h0000_0000;

  // Expected reply encodings
  typedef enum logic [2:0] {
    SDCC_RESP_R1_R6 = 3'h0,
    SDCC_RESP_R1B = 3'h1,
    SDCC_RESP_R2 = 3'h2,
    SDCC_RESP_R3_R4 = 3'h3,
    SDCC_RESP_NONE = 3'h4
  } sdcc_resp_t;

  // Data bus width encodings
  typedef enum logic [1:0] {
    SDCC_BUS_1BIT = 2'h0,
    SDCC_BUS_4BIT = 2'h1,
    SDCC_BUS_8BIT = 2'h2,
    SDCC_BUS_RSVD = 2'h3
  } sdcc_width_t;

  // Card clock edges needed per byte for each bus width
  localparam logic [3:0] SDCC_EDGES_1BIT = 4'h8;
  localparam logic [3:0] SDCC_EDGES_4BIT = 4'h2;
  localparam logic [3:0] SDCC_EDGES_8BIT = 4'h1;

endpackage

// ---- logic/sdcc_ctrl.sv ----
// Card command issue and data-path control with its APB register file.
// Assumes the card clock and data line 1 arrive from pins, asynchronous to clk;
// a separate command engine consumes cmd_start and the command fields.
// Response capture, FIFOs and the clock divider sit outside; this block only
// paces bytes from card clock edges and raises the matching events.
// Outputs are all registered; the bus answers with no wait states.
//
// Notes on behaviour
// - Transfer length field in bits 31..16 sets bytes moved before completion interrupt.
// - Reading the length field returns bytes still remaining, not the written value.
// - No data-path operation starts unless the go bit, bit 1, is one.
// - Argument register holds the 32-bit argument; reads return the last written value.
// - Reply field bits 10..8: R1/R6, R1b, R2, R3/R4, or no reply.
// - Bit 6 flags a data command when one, a non-data command when zero.
// - In 4-bit mode, the data flag bounds when a line-1 card interrupt is valid.
// - Bits 5..0 hold the command index; writing the register starts the command.
// - Reading the command register returns the last written command index.
// - Argument, command and transfer control registers all reset to zero.
// - Block size is two to the programmed exponent; transfers are split into blocks.
// - Bus width 00 one line, 01 four lines, 10 eight lines, 11 reserved.
`timescale 1ns/100ps

// Register map on the APB, one aligned word each:
//   config: bus width and block size exponent
//   transfer control: length counting down, go, direction
//   command argument and command issue (reply type, data flag, index)
//   interrupt status (read only), clear (write ones), enable
// Status bits: transfer done, block done, card interrupt, command sent.
// Every access has one setup and one access cycle; pready never waits.
// A command write pulses cmd_start; the data path opens in that same cycle
// only when go is set and the length is not zero.
// Bytes take 8, 2 or 1 rising card clock edges at 1, 4 or 8 lines.
// Reserved width and block exponent zero fall back to the narrowest case.
// Writing transfer control aborts any transfer that is still running.
// Status sets win over a clear written in the same cycle.

module sdcc_ctrl
  import sdcc_pkg::*;
#(
  parameter int LEN_W = SDCC_XFER_LEN_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_clk,
  input wire logic card_dat1_line,
  output logic cmd_start,
  output logic [SDCC_CMD_INDEX_W-1:0] cmd_index,
  output logic [31:0] cmd_arg,
  output logic [SDCC_CMD_RESP_W-1:0] cmd_resp_type,
  output logic cmd_data_flag,
  output logic data_active,
  output logic data_dir,
  output logic byte_strobe,
  output logic block_strobe,
  output logic [1:0] bus_width,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the whole block in one record
  typedef struct packed {
    // Register bus answer
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    // Configuration and transfer control
    logic [3:0] bsize_exp;
    logic [1:0] width;
    logic [LEN_W-1:0] remaining;
    logic go;
    logic dir;
    // Command fields
    logic [31:0] arg;
    logic [SDCC_CMD_RESP_W-1:0] resp;
    logic data_flag;
    logic [SDCC_CMD_INDEX_W-1:0] index;
    logic start;
    // Data path pacing
    logic active;
    logic [3:0] edge_cnt;
    logic [LEN_W:0] block_cnt;
    logic byte_pulse;
    logic block_pulse;
    // Interrupts
    logic [SDCC_INT_W-1:0] int_status;
    logic [SDCC_INT_W-1:0] int_enable;
    logic irq;
    // Pin synchronisers
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic dat1_s1;
    logic dat1_s2;
  } sdcc_state_t;

  sdcc_state_t st_q;
  sdcc_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Card clock edges per byte; reserved width falls back to one line
  // Pacing counts bytes only; bit order on the lines is the card engine's concern
  function automatic logic [3:0] edges_per_byte(input logic [1:0] w);
    unique case (w)
      SDCC_BUS_4BIT: edges_per_byte = SDCC_EDGES_4BIT;
      SDCC_BUS_8BIT: edges_per_byte = SDCC_EDGES_8BIT;
      default: edges_per_byte = SDCC_EDGES_1BIT;
    endcase
  endfunction

  // Block size in bytes from the exponent
  // Exponent zero is reserved; it yields one-byte blocks here
  function automatic logic [LEN_W:0] block_bytes(input logic [3:0] e);
    block_bytes = (LEN_W+1)'(1) << e;
  endfunction

  // Address decode shared by the read and write paths
  // One function so reads and writes agree on which offsets are holes
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == SDCC_OFF_CONFIG) || (a == SDCC_OFF_XFER_CTRL) ||
                (a == SDCC_OFF_CMD_ARG) || (a == SDCC_OFF_CMD_ISSUE) ||
                (a == SDCC_OFF_INT_STATUS) || (a == SDCC_OFF_INT_CLEAR) ||
                (a == SDCC_OFF_INT_ENABLE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  // Every field holds unless a branch below changes it
  always_comb begin
    logic setup;
    logic access;
    logic wr;
    logic card_edge;
    logic last_byte;
    logic block_end;
    logic card_irq;
    logic [SDCC_INT_W-1:0] events;
    logic [SDCC_INT_W-1:0] clr;
    logic reprogram;
    setup = 1'b0;
    reprogram = 1'b0;
    access = 1'b0;
    wr = 1'b0;
    card_edge = 1'b0;
    last_byte = 1'b0;
    block_end = 1'b0;
    card_irq = 1'b0;
    events = '0;
    clr = '0;
    st_d = st_q;

    // Two-flop synchronisers, then a third flop for edge finding
    // Line 1 syncs reset low, but width resets to one line: no false card interrupt
    st_d.clk_s1 = card_clk;
    st_d.clk_s2 = st_q.clk_s1;
    st_d.clk_s3 = st_q.clk_s2;
    st_d.dat1_s1 = card_dat1_line;
    st_d.dat1_s2 = st_q.dat1_s1;
    card_edge = st_q.clk_s2 && !st_q.clk_s3;

    // APB: ready is raised in the access phase, one edge after setup
    // A registered ready costs nothing here, as every access phase lasts exactly one cycle
    setup = psel && !penable;
    access = psel && penable && st_q.ready;
    wr = access && pwrite && !st_q.slverr;
    st_d.ready = setup;
    st_d.slverr = setup && !is_mapped(paddr);
    st_d.start = 1'b0;
    st_d.byte_pulse = 1'b0;
    st_d.block_pulse = 1'b0;

    // Read data is captured during setup so it is stable in the access phase
    // A byte counted in that same cycle shows on the next read, not this one
    if (setup) begin
      st_d.rdata = SDCC_RESET_WORD;
      unique case (paddr)
        SDCC_OFF_CONFIG: begin
          st_d.rdata[SDCC_CFG_WIDTH_LSB +: 2] = st_q.width;
          st_d.rdata[SDCC_CFG_BSIZE_W-1:0] = st_q.bsize_exp;
        end
        SDCC_OFF_XFER_CTRL: begin
          st_d.rdata[SDCC_XFER_LEN_LSB +: LEN_W] = st_q.remaining;
          st_d.rdata[SDCC_XFER_GO_BIT] = st_q.go;
          st_d.rdata[SDCC_XFER_DIR_BIT] = st_q.dir;
        end
        SDCC_OFF_CMD_ARG: begin
          st_d.rdata = st_q.arg;
        end
        SDCC_OFF_CMD_ISSUE: begin
          st_d.rdata[SDCC_CMD_RESP_LSB +: SDCC_CMD_RESP_W] = st_q.resp;
          st_d.rdata[SDCC_CMD_DATA_BIT] = st_q.data_flag;
          st_d.rdata[SDCC_CMD_INDEX_W-1:0] = st_q.index;
        end
        SDCC_OFF_INT_STATUS: begin
          st_d.rdata[SDCC_INT_W-1:0] = st_q.int_status;
        end
        SDCC_OFF_INT_ENABLE: begin
          st_d.rdata[SDCC_INT_W-1:0] = st_q.int_enable;
        end
        default: begin
          st_d.rdata = SDCC_RESET_WORD; // Clear register and holes read zero
        end
      endcase
    end

    // Register writes take effect on the completing access edge
    // Unmapped offsets never get here; pslverr already refused them
    if (wr) begin
      unique case (paddr)
        SDCC_OFF_CONFIG: begin
          st_d.width = pwdata[SDCC_CFG_WIDTH_LSB +: 2];
          st_d.bsize_exp = pwdata[SDCC_CFG_BSIZE_W-1:0];
        end
        SDCC_OFF_XFER_CTRL: begin
          // Length then counts down in place, so a read shows what is left
          reprogram = 1'b1;
          st_d.remaining = pwdata[SDCC_XFER_LEN_LSB +: LEN_W];
          st_d.go = pwdata[SDCC_XFER_GO_BIT];
          st_d.dir = pwdata[SDCC_XFER_DIR_BIT];
          st_d.active = 1'b0; // Reprogramming aborts any transfer in flight
          st_d.edge_cnt = '0;
          st_d.block_cnt = '0;
        end
        SDCC_OFF_CMD_ARG: begin
          st_d.arg = pwdata;
        end
        SDCC_OFF_CMD_ISSUE: begin
          st_d.resp = pwdata[SDCC_CMD_RESP_LSB +: SDCC_CMD_RESP_W];
          st_d.data_flag = pwdata[SDCC_CMD_DATA_BIT];
          st_d.index = pwdata[SDCC_CMD_INDEX_W-1:0];
          // Issue never waits for the data path; the command engine owns the card
          st_d.start = 1'b1;
          events[SDCC_INT_CMD_SENT] = 1'b1;
          // Data path only opens with go set and bytes to move
          if (st_q.go && (st_q.remaining != '0)) begin
            st_d.active = 1'b1;
            st_d.edge_cnt = '0;
            st_d.block_cnt = '0;
          end
        end
        SDCC_OFF_INT_CLEAR: begin
          // Ones clear status bits; zeros leave them alone
          clr = pwdata[SDCC_INT_W-1:0];
        end
        SDCC_OFF_INT_ENABLE: begin
          st_d.int_enable = pwdata[SDCC_INT_W-1:0];
        end
        default: begin
          st_d.int_enable = st_q.int_enable; // Read-only status ignores writes
        end
      endcase
    end

    // Byte pacing from card clock edges at the configured width
    // Only rising card clock edges count; a stalled clock leaves the path open
    // A transfer control write in the same cycle wins, so its new length is kept
    if (st_q.active && card_edge && !reprogram) begin
      if (st_q.edge_cnt + 4'h1 >= edges_per_byte(st_q.width)) begin
        st_d.edge_cnt = '0;
        st_d.byte_pulse = 1'b1;
        st_d.remaining = st_q.remaining - LEN_W'(1);
        last_byte = (st_q.remaining == LEN_W'(1));
        block_end = (st_q.block_cnt + (LEN_W+1)'(1) >= block_bytes(st_q.bsize_exp));
        st_d.block_cnt = block_end ? '0 : st_q.block_cnt + (LEN_W+1)'(1);
      end else begin
        st_d.edge_cnt = st_q.edge_cnt + 4'h1;
      end
    end

    // Block boundary and completion events
    // Both go to sticky status; only enabled ones reach irq
    if (block_end) begin
      st_d.block_pulse = 1'b1;
      events[SDCC_INT_BLOCK_DONE] = 1'b1;
    end
    if (last_byte) begin
      st_d.active = 1'b0;
      st_d.go = 1'b0; // Stops the path so completion cannot repeat
      events[SDCC_INT_XFER_DONE] = 1'b1;
    end

    // Card interrupt on line 1: only in 4-bit mode, outside a data window
    // Line 1 carries data during a data command, so a low level there is no interrupt
    // Limitation: the status bit sets again every cycle the line stays low
    card_irq = (st_q.width == SDCC_BUS_4BIT) && !st_q.dat1_s2 &&
               !(st_q.data_flag && st_q.active);
    events[SDCC_INT_CARD_IRQ] = card_irq;

    // Sticky status: a new event wins over a clear in the same cycle
    // irq is registered from the next status, so it moves with status but trails an enable change by one cycle
    st_d.int_status = (st_q.int_status & ~clr) | events;
    st_d.irq = |(st_d.int_status & st_q.int_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; everything resets to zero
  // Only constants in the reset branch; the record is cleared as a whole
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state record
  // Every output is a flop of the record, so no decode glitch reaches a pin
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.slverr;

  // Command engine side
  assign cmd_start = st_q.start;
  assign cmd_index = st_q.index;
  assign cmd_arg = st_q.arg;
  assign cmd_resp_type = st_q.resp;
  assign cmd_data_flag = st_q.data_flag;

  // Data path side
  assign data_active = st_q.active;
  assign data_dir = st_q.dir;
  assign byte_strobe = st_q.byte_pulse;
  assign block_strobe = st_q.block_pulse;
  assign bus_width = st_q.width;

  // Interrupt
  assign irq = st_q.irq;

endmodule // sdcc_ctrl

// ---- testbench/sdcc_card_model.sv ----
// Behavioural card: supplies the card clock and data line 1.
// Assumes the bench calls its tasks; line 1 idles high on its pull-up.
`timescale 1ns/100ps
module sdcc_card_model (
  output logic card_clk,
  output logic card_dat1_line
);
  // Idle levels: clock parked low, line pulled up
  initial begin
    card_clk = 1'b0;
    card_dat1_line = 1'b1;
  end
  // Clock runs only inside a frame; odd offset keeps it off the system clock phase
  task burst(input int n, input int half);
    #3.7;
    repeat (n) begin
      #half card_clk = 1'b1;
      #half card_clk = 1'b0;
    end
  endtask
  // Card pulls line 1 low to ask for attention
  task pull(input int ns);
    card_dat1_line = 1'b0;
    #ns card_dat1_line = 1'b1;
  endtask
endmodule // sdcc_card_model

// ---- testbench/sdcc_ctrl_assertions.sv ----
// Checker for the command and data control block, bound to its top.
// Assumes one clock domain and the zero-wait APB answer of the design.
`timescale 1ns/100ps
module sdcc_ctrl_assertions (
  input logic clk,
  input logic reset_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic cmd_start,
  input logic [5:0] cmd_index,
  input logic [31:0] cmd_arg,
  input logic [2:0] cmd_resp_type,
  input logic cmd_data_flag,
  input logic data_active,
  input logic data_dir,
  input logic [1:0] bus_width
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Completed write, shared by the register checks
  wire wr = psel && penable && pready && pwrite;
  AST_PREADY: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  AST_CMD_START: assert property (wr && paddr == 8'h1c |=> cmd_start ##1 !cmd_start)
    else $error("command start missing or long");
  AST_CMD_FIELDS: assert property (cmd_start |-> cmd_index == $past(pwdata[5:0]) &&
    cmd_resp_type == $past(pwdata[10:8]) && cmd_data_flag == $past(pwdata[6])) else $error("command fields wrong");
  AST_ARG: assert property (wr && paddr == 8'h18 |=> cmd_arg == $past(pwdata)) else $error("argument wrong");
  AST_GO_RISE: assert property ($rose(data_active) |-> cmd_start) else $error("data path started alone");
  AST_GO_OFF: assert property (wr && paddr == 8'h14 && !pwdata[1] |=> !data_active[*8])
    else $error("data path ran without go");
  AST_DIR: assert property (wr && paddr == 8'h14 |=> data_dir == $past(pwdata[0])) else $error("direction wrong");
  AST_WIDTH: assert property (wr && paddr == 8'h10 |=> bus_width == $past(pwdata[13:12]))
    else $error("bus width wrong");
  AST_RST: assert property ($rose(reset_n) |-> !cmd_start && !data_active && cmd_arg == 32'h0 &&
    cmd_index == 6'h0) else $error("outputs not clear after reset");
endmodule // sdcc_ctrl_assertions
bind sdcc_ctrl sdcc_ctrl_assertions u_chk (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .cmd_start, .cmd_index, .cmd_arg, .cmd_resp_type, .cmd_data_flag, .data_active, .data_dir, .bus_width);

// ---- testbench/tb.sv ----
// Self-checking bench: APB master, card model, queued read checks.
// Assumes zero-wait APB slave and a 160 ns card clock.
`timescale 1ns/100ps
module tb;
  import sdcc_pkg::*;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, cmd_arg, a, c, rs = 32'h0000_5f12;
  logic pready, pslverr, card_clk, card_dat1_line, cmd_start, cmd_data_flag, data_active, data_dir, byte_strobe;
  logic block_strobe, irq;
  logic [5:0] cmd_index;
  logic [2:0] cmd_resp_type;
  logic [1:0] bus_width;
  logic [32:0] q[$];
  int err_count = 0, checked = 0, cyc = 0, nbyte = 0, nblk = 0, e;
  always #4 clk = ~clk;
  sdcc_ctrl u_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .card_clk, .card_dat1_line, .cmd_start, .cmd_index, .cmd_arg, .cmd_resp_type, .cmd_data_flag,
    .data_active, .data_dir, .byte_strobe, .block_strobe, .bus_width, .irq);
  sdcc_card_model u_card (.card_clk, .card_dat1_line);
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; holds the request until ready is sampled
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [7:0] ad, input logic [32:0] x);
    q.push_back(x);
    apb(0, ad, 32'h0);
  endtask
  ///////////////////////////////////////////////////////////////////////////
  // Watchdog: a hang counts as a mismatch and still reaches the verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done;
    end
  end
  // Strobe counters and the read-data monitor
  always @(posedge clk) begin
    if (byte_strobe === 1'b1) nbyte++;
    if (block_strobe === 1'b1) nblk++;
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, q.pop_front());
  end
  ///////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1;
    rd(SDCC_OFF_XFER_CTRL, 33'h0);
    rd(SDCC_OFF_CMD_ARG, 33'h0);
    rd(SDCC_OFF_CMD_ISSUE, 33'h0);
    a = rnd();
    apb(1, SDCC_OFF_CMD_ARG, a);
    rd(SDCC_OFF_CMD_ARG, {1'b0, a});
    chk(cmd_arg, a);
    // Every reply code, random index and data flag
    for (int r = 0; r < 5; r++) begin
      c = (rnd() & 32'h0000_007f) | (r << 8);
      apb(1, SDCC_OFF_CMD_ISSUE, c);
      rd(SDCC_OFF_CMD_ISSUE, {1'b0, c});
      chk(cmd_resp_type, r);
      chk(cmd_index, c[5:0]);
      chk(cmd_data_flag, c[6]);
    end
    // Line-1 interrupt counts only in 4-bit mode
    apb(1, SDCC_OFF_INT_ENABLE, 32'h0000_0004);
    apb(1, SDCC_OFF_CONFIG, 32'h0);
    u_card.pull(200);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    apb(1, SDCC_OFF_CONFIG, 32'h0000_1000);
    u_card.pull(200);
    repeat (3) @(posedge clk);
    chk(irq, 1);
    apb(1, SDCC_OFF_INT_CLEAR, 32'h0000_000f);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    // Go clear: command goes out, data path stays idle
    apb(1, SDCC_OFF_XFER_CTRL, 32'h0002_0000);
    apb(1, SDCC_OFF_CMD_ISSUE, 32'h0000_0011);
    u_card.burst(20, 80);
    chk(data_active, 0);
    chk(nbyte, 0);
    rd(SDCC_OFF_XFER_CTRL, 33'h0_0002_0000);
    // Four bytes in blocks of two, each bus width, alternating direction
    for (int w = 0; w < 3; w++) begin
      e = (w == 0) ? 8 : (w == 1) ? 2 : 1;
      apb(1, SDCC_OFF_CONFIG, (w << 12) | 1);
      apb(1, SDCC_OFF_INT_ENABLE, 32'h0000_0001);
      apb(1, SDCC_OFF_INT_CLEAR, 32'h0000_000f);
      apb(1, SDCC_OFF_XFER_CTRL, 32'h0004_0002 | w[0]);
      apb(1, SDCC_OFF_CMD_ISSUE, 32'h0000_0051);
      nbyte = 0;
      nblk = 0;
      @(posedge clk);
      chk(data_active, 1);
      chk(data_dir, w[0]);
      chk(bus_width, w);
      rd(SDCC_OFF_CONFIG, (w << 12) | 1);
      u_card.burst(3 * e, 80);
      repeat (6) @(posedge clk);
      rd(SDCC_OFF_XFER_CTRL, 33'h0_0001_0002 | w[0]);
      chk(nbyte, 3);
      chk(nblk, 1);
      chk(irq, 0);
      u_card.pull(200);
      rd(SDCC_OFF_INT_STATUS, 33'h0_0000_000a);
      u_card.burst(e, 80);
      repeat (6) @(posedge clk);
      chk(data_active, 0);
      chk(nbyte, 4);
      chk(nblk, 2);
      chk(irq, 1);
      rd(SDCC_OFF_XFER_CTRL, w[0]);
    end
    apb(1, SDCC_OFF_INT_ENABLE, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    rd(8'h3c, 33'h1_0000_0000);
    repeat (4) @(posedge clk);
    test_done;
  end
endmodule // tb
